// ==== rtl/lidc_pkg.sv ====
// Package: constants, types and helpers of the link init / dormant / config controller
// Notes on behaviour
// - Dormant recovery skips init; config done goes straight to active, else config.
// - Idle-entry command moves link to dormant; machines reset, registers kept.
// - Without deep power-save support, a request bit of one is illegal.
// - Deep power-save support is reported at PHY capability bit 15.
// - Starting device subtracts own power from group budget; budget 0 reserved.
// - Device allowance is n times 360 mW; 0 means default 360 mW.
// - Device not finished initializing clears the completion flag.
// - Init command accepted only in config state; otherwise illegal, not forwarded.
// - Config register holds capability, settings and preset fields.
// - Without application layer block length follows max setting immediately.
// - Application layer block length never exceeds negotiated maximum.
// - Storage application uses 512 byte maximum block length.
// - Inquiry reaching beyond capability words is discarded.
// - Inquiry merges own capability into payload and forwards it.
// - Inquiry leaves reserved and no-operation bits untouched.
// - Common write stores payload into the addressed settings words only.
package lidc_pkg;

   typedef enum logic [2:0] {
      LIDC_K_PHY_READY = 3'h0,
      LIDC_K_BSYNC = 3'h1,
      LIDC_K_DORMANT = 3'h2,
      LIDC_K_DEV_INIT = 3'h3,
      LIDC_K_ENUM = 3'h4,
      LIDC_K_INQUIRY = 3'h5,
      LIDC_K_SET_COMMON = 3'h6
   } lidc_kind_e;

   typedef enum logic [1:0] {
      LIDC_LS_DORMANT = 2'h0,
      LIDC_LS_CONFIG = 2'h1,
      LIDC_LS_ACTIVE = 2'h3
   } lidc_link_state_e;

   typedef enum logic [1:0] {
      LIDC_ST_IDLE = 2'h0,
      LIDC_ST_WALK = 2'h1,
      LIDC_ST_MERGE = 2'h3,
      LIDC_ST_SEND = 2'h2
   } lidc_step_e;

   typedef struct packed {
      lidc_kind_e kind;
      logic deep_power_save_request;
      logic [3:0] group_number;
      logic [3:0] group_power_budget;
      logic [3:0] device_power_allowance;
      logic completion_flag;
      logic [7:0] register_word_address;
      logic [1:0] payload_length;
      logic [127:0] payload;
   } lidc_cmd_s;

   // Word addresses of the config register
   localparam logic [7:0] LIDC_CAP_LAST = 8'h05;
   localparam logic [7:0] LIDC_SET_FIRST = 8'h08;
   localparam logic [7:0] LIDC_SET_LAST = 8'h0D;
   localparam logic [7:0] LIDC_PRESET_FIRST = 8'h40;
   localparam logic [7:0] LIDC_PRESET_LAST = 8'h41;
   localparam logic [7:0] LIDC_GEN_CAP_LO = 8'h00;
   localparam logic [7:0] LIDC_GEN_CAP_HI = 8'h01;
   localparam logic [7:0] LIDC_PHY_CAP_LO = 8'h02;
   localparam logic [7:0] LIDC_LT_CAP_LO = 8'h04;
   localparam logic [7:0] LIDC_GEN_SET_HI = 8'h09;
   localparam logic [7:0] LIDC_PHY_SET_LO = 8'h0A;
   localparam logic [7:0] LIDC_LT_SET_LO = 8'h0C;
   // Field positions
   localparam int LIDC_DPS_CAP_BIT = 15;
   localparam int LIDC_APP_MEM_BIT = 16;
   localparam int LIDC_CFG_DONE_BIT = 31;
   localparam int LIDC_RANGE_LSB = 6;
   localparam int LIDC_BLKLEN_LSB = 0;
   localparam int LIDC_FIRST_NODE_LSB = 0;
   localparam int LIDC_LAST_NODE_LSB = 4;
   // Reset values, keep masks and default allowance
   localparam logic [11:0] LIDC_STORAGE_BLKLEN = 12'h200;
   localparam logic [31:0] LIDC_GEN_CAP_KEEP = 32'h00FF_C000;
   localparam logic [31:0] LIDC_ALL_KEEP = 32'hFFFF_FFFF;
   localparam logic [3:0] LIDC_DEFAULT_ALLOW = 4'h1;

   function automatic logic [3:0] lidc_cfg_index(input logic [7:0] a);
      lidc_cfg_index = (a >= LIDC_PRESET_FIRST) ? {3'h7, a[0]} : a[3:0];
   endfunction

   function automatic logic lidc_is_settings(input logic [7:0] a);
      lidc_is_settings = (a >= LIDC_SET_FIRST) && (a <= LIDC_SET_LAST);
   endfunction

   function automatic logic [2:0] lidc_payload_length_words(input logic [1:0] p);
      lidc_payload_length_words = (p == 2'h3) ? 3'h4 : {1'b0, p};
   endfunction

   function automatic logic [31:0] lidc_keep_mask(input logic [7:0] a);
      if (a == LIDC_GEN_CAP_LO) begin
         lidc_keep_mask = LIDC_GEN_CAP_KEEP;
      end else if (a == LIDC_GEN_CAP_HI) begin
         lidc_keep_mask = LIDC_ALL_KEEP;
      end else begin
         lidc_keep_mask = 32'h0000_0000;
      end
   endfunction

   function automatic logic [31:0] lidc_cfg_reset(input logic [3:0] i, input logic dps);
      logic [31:0] w;
      w = 32'h0000_0000;
      if (i == LIDC_GEN_CAP_LO[3:0]) w[LIDC_APP_MEM_BIT] = 1'b1;
      if (i == LIDC_PHY_CAP_LO[3:0]) w[LIDC_DPS_CAP_BIT] = dps;
      if (i == LIDC_LT_CAP_LO[3:0] || i == LIDC_LT_SET_LO[3:0]) begin
         w[LIDC_BLKLEN_LSB +: 12] = LIDC_STORAGE_BLKLEN;
      end
      lidc_cfg_reset = w;
   endfunction

endpackage

// ==== rtl/lidc_cfg_mem.sv ====
// Config register words: capability, settings and preset storage
`timescale 1ns/1ps
`default_nettype none
module lidc_cfg_mem
   import lidc_pkg::*;
#(
   parameter bit DPS_SUPPORT = 1'b0
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   // Read port
   input wire logic [3:0] rd_idx_i,
   output logic [31:0] rd_data_o,
   // Write port
   input wire logic wr_en_i,
   input wire logic [3:0] wr_idx_i,
   input wire logic [31:0] wr_data_i
);
   logic [31:0] mem_ff [16];

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int i = 0; i < 16; i++) begin
            mem_ff[i] <= lidc_cfg_reset(4'(i), DPS_SUPPORT);
         end
         rd_data_o <= 32'h0000_0000;
      end else begin
         if (wr_en_i) mem_ff[wr_idx_i] <= wr_data_i;
         rd_data_o <= mem_ff[rd_idx_i];
      end
   end
endmodule
`default_nettype wire

// ==== rtl/lidc_cmd_cdc.sv ====
// Toggle handshake carrying decoded commands from link clock to system clock
`timescale 1ns/1ps
`default_nettype none
module lidc_cmd_cdc
   import lidc_pkg::*;
(
   // Clocks and reset
   input wire logic clk_link_i,
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   // Link side
   input wire logic in_valid_i,
   input wire lidc_cmd_s in_cmd_i,
   output logic in_ready_o,
   // System side
   input wire logic out_ready_i,
   output logic out_pulse_o,
   output lidc_cmd_s out_cmd_o
);
   logic req_tgl_ff;
   logic ack_s1_ff;
   logic ack_s2_ff;
   lidc_cmd_s hold_ff;
   logic req_s1_ff;
   logic req_s2_ff;
   logic ack_tgl_ff;
   wire logic take_link = in_valid_i && in_ready_o;
   wire logic take_sys = (req_s2_ff != ack_tgl_ff) && out_ready_i;

   // One word in flight; hold stays stable until the ack returns
   assign in_ready_o = (req_tgl_ff == ack_s2_ff);

   always_ff @(posedge clk_link_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         req_tgl_ff <= 1'b0;
         ack_s1_ff <= 1'b0;
         ack_s2_ff <= 1'b0;
         hold_ff <= '0;
      end else begin
         ack_s1_ff <= ack_tgl_ff;
         ack_s2_ff <= ack_s1_ff;
         if (take_link) begin
            req_tgl_ff <= ~req_tgl_ff;
            hold_ff <= in_cmd_i;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         req_s1_ff <= 1'b0;
         req_s2_ff <= 1'b0;
         ack_tgl_ff <= 1'b0;
         out_pulse_o <= 1'b0;
         out_cmd_o <= '0;
      end else begin
         req_s1_ff <= req_tgl_ff;
         req_s2_ff <= req_s1_ff;
         out_pulse_o <= take_sys;
         if (take_sys) begin
            ack_tgl_ff <= req_s2_ff;
            out_cmd_o <= hold_ff;
         end
      end
   end
endmodule
`default_nettype wire

// ==== rtl/lidc_link_ctrl.sv ====
// Link management command interpreter: dormant entry, device init, numbering, config
`timescale 1ns/1ps
`default_nettype none
module lidc_link_ctrl
   import lidc_pkg::*;
#(
   parameter bit DPS_SUPPORT = 1'b0
) (
   // Clocks and reset
   input wire logic clk_sys_i,
   input wire logic clk_link_i,
   input wire logic arst_n_i,
   // Decoded commands from the link receiver, link clock
   input wire logic link_cmd_valid_i,
   input wire lidc_cmd_s link_cmd_i,
   output logic link_cmd_ready_o,
   // Commands forwarded to the next node, system clock
   output logic fwd_valid_o,
   output lidc_cmd_s fwd_cmd_o,
   output logic illegal_o,
   output lidc_kind_e illegal_kind_o,
   // Device core, system clock
   input wire logic [3:0] own_power_i,
   input wire logic dev_init_done_i,
   input wire logic app_layer_present_i,
   input wire logic [11:0] app_block_len_i,
   // Status
   output lidc_link_state_e link_state_o,
   output logic init_started_o,
   output logic config_done_o,
   output logic dps_active_o,
   output logic [1:0] speed_range_o,
   output logic [3:0] node_number_o,
   output logic [11:0] block_length_o
);
   lidc_cmd_s rx_cmd;
   logic rx_pulse;
   logic [31:0] rd_data;
   lidc_step_e step_ff;
   lidc_cmd_s work_ff;
   logic [1:0] ptr_ff;
   logic [1:0] sel_range_ff;
   logic [11:0] max_blk_ff;
   logic illegal_ff;
   lidc_kind_e illegal_kind_ff;

   lidc_cmd_cdc u_cdc (
      .clk_link_i(clk_link_i),
      .clk_sys_i(clk_sys_i),
      .arst_n_i(arst_n_i),
      .in_valid_i(link_cmd_valid_i),
      .in_cmd_i(link_cmd_i),
      .in_ready_o(link_cmd_ready_o),
      .out_ready_i(step_ff == LIDC_ST_IDLE),
      .out_pulse_o(rx_pulse),
      .out_cmd_o(rx_cmd)
   );

   // Word walk addressing
   wire logic [7:0] cur_addr = work_ff.register_word_address + {6'h00, ptr_ff};
   wire logic [2:0] nwords = lidc_payload_length_words(work_ff.payload_length);
   wire logic last_word = ({1'b0, ptr_ff} + 3'h1) >= nwords;
   wire logic [31:0] cur_word = work_ff.payload[{ptr_ff, 5'h00} +: 32];
   wire logic is_inquiry = (work_ff.kind == LIDC_K_INQUIRY);
   // Inquiry keeps no-op and reserved bits, ANDs the rest with own capability
   wire logic [31:0] merged = cur_word & (rd_data | lidc_keep_mask(cur_addr));
   wire logic [31:0] new_word = is_inquiry ? merged : cur_word;
   wire logic cfg_write = (step_ff == LIDC_ST_MERGE) && !is_inquiry
      && lidc_is_settings(cur_addr);
   wire logic [31:0] cfg_wdata = cur_word;

   lidc_cfg_mem #(
      .DPS_SUPPORT(DPS_SUPPORT)
   ) u_cfg (
      .clk_sys_i(clk_sys_i),
      .arst_n_i(arst_n_i),
      .rd_idx_i(lidc_cfg_index(cur_addr)),
      .rd_data_o(rd_data),
      .wr_en_i(cfg_write),
      .wr_idx_i(lidc_cfg_index(cur_addr)),
      .wr_data_i(cfg_wdata)
   );

   // Inquiry range must lie wholly within the capability words
   wire logic [8:0] inq_end = {1'b0, rx_cmd.register_word_address}
      + {6'h00, lidc_payload_length_words(rx_cmd.payload_length)};
   wire logic inq_in_range = (inq_end <= {1'b0, LIDC_CAP_LAST} + 9'h001);

   // Device init decision
   wire logic [3:0] eff_allow = (rx_cmd.device_power_allowance == 4'h0) ?
      LIDC_DEFAULT_ALLOW : rx_cmd.device_power_allowance;
   wire logic budget_ok = (rx_cmd.group_power_budget != 4'h0)
      && (own_power_i <= rx_cmd.group_power_budget) && (own_power_i <= eff_allow);
   wire logic init_start = !init_started_o && !dev_init_done_i && budget_ok;
   wire logic [3:0] budget_out = init_start ?
      rx_cmd.group_power_budget - own_power_i : rx_cmd.group_power_budget;
   wire logic cf_out = dev_init_done_i ? rx_cmd.completion_flag : 1'b0;

   // Single-step decode of the received command
   wire logic in_config = (link_state_o == LIDC_LS_CONFIG);
   wire logic dps_bad = rx_cmd.deep_power_save_request && !DPS_SUPPORT;
   wire logic init_bad = (rx_cmd.kind == LIDC_K_DEV_INIT) && !in_config;
   wire logic dorm_bad = (rx_cmd.kind == LIDC_K_DORMANT) && dps_bad;
   wire logic rx_illegal = rx_pulse && (init_bad || dorm_bad);
   wire logic rx_walk = rx_pulse && ((rx_cmd.kind == LIDC_K_SET_COMMON)
      || ((rx_cmd.kind == LIDC_K_INQUIRY) && inq_in_range));
   wire logic rx_fwd_now = rx_pulse && !rx_illegal
      && ((rx_cmd.kind == LIDC_K_DORMANT) || (rx_cmd.kind == LIDC_K_DEV_INIT)
      || (rx_cmd.kind == LIDC_K_ENUM));
   wire logic walk_empty = (lidc_payload_length_words(rx_cmd.payload_length) == 3'h0);
   wire logic [3:0] first_node = rx_cmd.payload[LIDC_FIRST_NODE_LSB +: 4];

   // Command as handed on when it leaves in one step
   lidc_cmd_s one_step;
   always_comb begin
      one_step = rx_cmd;
      if (rx_cmd.kind == LIDC_K_DEV_INIT) begin
         one_step.group_power_budget = budget_out;
         one_step.completion_flag = cf_out;
      end
      if (rx_cmd.kind == LIDC_K_ENUM) begin
         one_step.payload[LIDC_FIRST_NODE_LSB +: 4] = first_node + 4'h1;
      end
   end

   // Step machine
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         step_ff <= LIDC_ST_IDLE;
         work_ff <= '0;
         ptr_ff <= 2'h0;
      end else begin
         case (step_ff)
            LIDC_ST_IDLE: begin
               ptr_ff <= 2'h0;
               if (rx_walk) begin
                  work_ff <= rx_cmd;
                  step_ff <= walk_empty ? LIDC_ST_SEND : LIDC_ST_WALK;
               end else if (rx_fwd_now) begin
                  work_ff <= one_step;
                  step_ff <= LIDC_ST_SEND;
               end
            end
            LIDC_ST_WALK: step_ff <= LIDC_ST_MERGE;
            LIDC_ST_MERGE: begin
               work_ff.payload[{ptr_ff, 5'h00} +: 32] <= new_word;
               ptr_ff <= ptr_ff + 2'h1;
               step_ff <= last_word ? LIDC_ST_SEND : LIDC_ST_WALK;
            end
            LIDC_ST_SEND: step_ff <= LIDC_ST_IDLE;
            default: step_ff <= LIDC_ST_IDLE;
         endcase
      end
   end

   // Forwarding and illegal reporting
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fwd_valid_o <= 1'b0;
         fwd_cmd_o <= '0;
         illegal_ff <= 1'b0;
         illegal_kind_ff <= LIDC_K_PHY_READY;
      end else begin
         fwd_valid_o <= (step_ff == LIDC_ST_SEND);
         if (step_ff == LIDC_ST_SEND) fwd_cmd_o <= work_ff;
         illegal_ff <= rx_illegal;
         if (rx_illegal) illegal_kind_ff <= rx_cmd.kind;
      end
   end
   assign illegal_o = illegal_ff;
   assign illegal_kind_o = illegal_kind_ff;

   // Shadow copies of settings that steer the link
   wire logic wr_done_word = cfg_write && (cur_addr == LIDC_GEN_SET_HI);
   wire logic wr_range_word = cfg_write && (cur_addr == LIDC_PHY_SET_LO);
   wire logic wr_blk_word = cfg_write && (cur_addr == LIDC_LT_SET_LO);

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         config_done_o <= 1'b0;
         sel_range_ff <= 2'h0;
         max_blk_ff <= LIDC_STORAGE_BLKLEN;
      end else begin
         if (wr_done_word) config_done_o <= cfg_wdata[LIDC_CFG_DONE_BIT];
         if (wr_range_word) sel_range_ff <= cfg_wdata[LIDC_RANGE_LSB +: 2];
         if (wr_blk_word) max_blk_ff <= cfg_wdata[LIDC_BLKLEN_LSB +: 12];
      end
   end

   // Link state machine
   wire logic rx_dormant = rx_pulse && (rx_cmd.kind == LIDC_K_DORMANT) && !dps_bad;
   wire logic rx_phy_ready = rx_pulse && (rx_cmd.kind == LIDC_K_PHY_READY);
   // Boundary sync after dormant recovery is dropped without any effect
   wire logic rx_init_ok = rx_pulse && (rx_cmd.kind == LIDC_K_DEV_INIT) && in_config;
   wire logic rx_enum = rx_pulse && (rx_cmd.kind == LIDC_K_ENUM);

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         link_state_o <= LIDC_LS_DORMANT;
         dps_active_o <= 1'b0;
         speed_range_o <= 2'h0;
      end else if (rx_dormant) begin
         link_state_o <= LIDC_LS_DORMANT;
         dps_active_o <= rx_cmd.deep_power_save_request;
         speed_range_o <= sel_range_ff;
      end else if (rx_phy_ready && link_state_o == LIDC_LS_DORMANT) begin
         dps_active_o <= 1'b0;
         link_state_o <= config_done_o ? LIDC_LS_ACTIVE : LIDC_LS_CONFIG;
      end
   end

   // Init progress and node number; init progress restarts on dormant entry
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         init_started_o <= 1'b0;
         node_number_o <= 4'h0;
      end else begin
         if (rx_dormant) begin
            init_started_o <= 1'b0;
         end else if (rx_init_ok && init_start) begin
            init_started_o <= 1'b1;
         end
         if (rx_enum) node_number_o <= first_node;
      end
   end

   // Block length: application layer value clipped to the negotiated maximum
   wire logic [11:0] app_clip = (app_block_len_i > max_blk_ff) ? max_blk_ff : app_block_len_i;
   wire logic [11:0] nxt_block_length = app_layer_present_i ? app_clip : max_blk_ff;

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         block_length_o <= LIDC_STORAGE_BLKLEN;
      end else begin
         block_length_o <= nxt_block_length;
      end
   end
endmodule
`default_nettype wire

// ==== tb/lidc_link_ctrl_checker.sv ====
// Port assertions for the link init / dormant / config controller
`timescale 1ns/1ps
`default_nettype none
module lidc_link_ctrl_checker
   import lidc_pkg::*;
#(
   parameter bit DPS_SUPPORT = 1'b0
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   // Forward and illegal outputs
   input wire logic fwd_valid_o,
   input wire lidc_cmd_s fwd_cmd_o,
   input wire logic illegal_o,
   input wire lidc_kind_e illegal_kind_o,
   // Device core
   input wire logic dev_init_done_i,
   input wire logic app_layer_present_i,
   input wire logic [11:0] app_block_len_i,
   // Status
   input wire lidc_link_state_e link_state_o,
   input wire logic init_started_o,
   input wire logic config_done_o,
   input wire logic [11:0] block_length_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);
   wire logic fwd_init = fwd_valid_o && fwd_cmd_o.kind == LIDC_K_DEV_INIT;
   wire logic fwd_dorm = fwd_valid_o && fwd_cmd_o.kind == LIDC_K_DORMANT;

   init_in_config_a: assert property (fwd_init |-> link_state_o == LIDC_LS_CONFIG)
      else $error("init forwarded outside config");
   init_refused_a: assert property (illegal_o && illegal_kind_o == LIDC_K_DEV_INIT
      |-> link_state_o != LIDC_LS_CONFIG) else $error("init refused in config");
   dps_refused_a: assert property (fwd_dorm |-> DPS_SUPPORT ||
      !fwd_cmd_o.deep_power_save_request) else $error("unsupported request forwarded");
   dormant_entry_a: assert property (fwd_dorm |-> link_state_o == LIDC_LS_DORMANT &&
      $past(link_state_o) == LIDC_LS_DORMANT) else $error("dormant not entered");
   flag_cleared_a: assert property (fwd_init && !dev_init_done_i && $stable(dev_init_done_i)
      |-> !fwd_cmd_o.completion_flag) else $error("completion flag kept");
   start_forward_a: assert property ($rose(init_started_o) |-> ##1 fwd_init)
      else $error("start without forward");
   app_blklen_a: assert property (app_layer_present_i && $past(app_layer_present_i)
      |-> block_length_o <= $past(app_block_len_i)) else $error("block length above app");
   dormant_exit_a: assert property (link_state_o == LIDC_LS_ACTIVE &&
      $past(link_state_o) == LIDC_LS_DORMANT |-> config_done_o) else $error("active early");

   cover property (fwd_valid_o && fwd_cmd_o.kind == LIDC_K_INQUIRY);
   cover property (illegal_o && illegal_kind_o == LIDC_K_DORMANT);
   cover property ($rose(init_started_o));
endmodule

bind lidc_link_ctrl lidc_link_ctrl_checker #(.DPS_SUPPORT(DPS_SUPPORT)) chk (.clk_sys_i,
   .arst_n_i, .fwd_valid_o, .fwd_cmd_o, .illegal_o, .illegal_kind_o, .dev_init_done_i,
   .app_layer_present_i, .app_block_len_i, .link_state_o, .init_started_o, .config_done_o,
   .block_length_o);
`default_nettype wire

// ==== tb/lidc_host_model.sv ====
// Host-side model offering decoded commands on the link clock
`timescale 1ns/1ps
`default_nettype none
module lidc_host_model
   import lidc_pkg::*;
(
   // Link clock and reset
   input wire logic clk_link_i,
   input wire logic arst_n_i,
   // Command handshake
   input wire logic ready_i,
   output logic valid_o,
   output lidc_cmd_s cmd_o
);
   logic left_dormant = 1'b0;
   initial begin
      valid_o = 1'b0;
      cmd_o = '0;
   end
   // Offer held until ready is seen at a link edge or 200 link edges pass
   task automatic send(input lidc_cmd_s c, output bit ok);
      int n;
      n = 0;
      ok = 1'b0;
      if (left_dormant && c.kind == LIDC_K_BSYNC) return;
      @(posedge clk_link_i);
      valid_o <= 1'b1;
      cmd_o <= c;
      do begin
         @(posedge clk_link_i);
         n++;
      end while (!(ready_i === 1'b1) && n < 200);
      ok = (ready_i === 1'b1);
      valid_o <= 1'b0;
      // Released lines must not keep the last value
      cmd_o <= ~c;
      if (c.kind == LIDC_K_DORMANT) left_dormant = 1'b1;
   endtask
endmodule
`default_nettype wire

// ==== tb/tb_lidc_link_ctrl.sv ====
// Self-checking bench for the link init / dormant / config controller
`timescale 1ns/1ps
`default_nettype none
module tb_lidc_link_ctrl;
   import lidc_pkg::*;
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
   $display("BAD %0t got %0h want %0h", $time, a, b); end end
   localparam logic [3:0] OW [5] = '{4'h3, 4'h2, 4'h1, 4'h1, 4'h2};
   localparam logic [3:0] GB [5] = '{4'h2, 4'h5, 4'h0, 4'h0, 4'h0};
   localparam logic [3:0] AL [5] = '{4'hF, 4'h0, 4'hF, 4'h0, 4'hF};
   localparam logic DN [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
   logic clk_sys = 1'b0;
   logic clk_link = 1'b0;
   logic arst_n = 1'b1;
   logic valid, ready, fwd_v, ill, started, cfg_done, dps, xs;
   lidc_cmd_s cmd, fwd_c, last, c;
   lidc_kind_e ill_k;
   lidc_link_state_e st;
   logic [3:0] own = 4'h0;
   logic done = 1'b0;
   logic app = 1'b0;
   logic [11:0] app_len = 12'h000;
   logic [1:0] rng;
   logic [3:0] node, eg;
   logic [11:0] blk, len, al;
   int error_cnt = 0;
   int samples_checked = 0;
   int n_fwd = 0;
   int n_ill = 0;

   always #5 clk_sys = ~clk_sys;
   initial begin
      #2.3;
      forever #32 clk_link = ~clk_link;
   end

   lidc_host_model host (.clk_link_i(clk_link), .arst_n_i(arst_n), .ready_i(ready),
      .valid_o(valid), .cmd_o(cmd));
   lidc_link_ctrl #(.DPS_SUPPORT(1'b0)) uut (.clk_sys_i(clk_sys), .clk_link_i(clk_link),
      .arst_n_i(arst_n), .link_cmd_valid_i(valid), .link_cmd_i(cmd), .link_cmd_ready_o(ready),
      .fwd_valid_o(fwd_v), .fwd_cmd_o(fwd_c), .illegal_o(ill), .illegal_kind_o(ill_k),
      .own_power_i(own), .dev_init_done_i(done), .app_layer_present_i(app),
      .app_block_len_i(app_len), .link_state_o(st), .init_started_o(started),
      .config_done_o(cfg_done), .dps_active_o(dps), .speed_range_o(rng),
      .node_number_o(node), .block_length_o(blk));

   always @(posedge clk_sys) begin
      if (fwd_v === 1'b1) begin
         n_fwd++;
         last = fwd_c;
      end
      if (ill === 1'b1) n_ill++;
   end

   function automatic lidc_cmd_s mk(input lidc_kind_e k);
      mk = '0;
      mk.kind = k;
      mk.payload = {$urandom(), $urandom(), $urandom(), $urandom()};
   endfunction

   function automatic logic [3:0] exp_gap(input lidc_cmd_s x, input logic [3:0] o,
      input logic s, input logic d);
      logic [3:0] lim;
      lim = (x.device_power_allowance == 4'h0) ? 4'h1 : x.device_power_allowance;
      exp_gap = x.group_power_budget;
      if (!s && !d && exp_gap != 4'h0 && o <= exp_gap && o <= lim) exp_gap = exp_gap - o;
   endfunction

   task automatic end_of_test();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // Bounded wait: a silent device is only legal when nothing is expected
   task automatic issue(input lidc_cmd_s x, input int ef, input int ei);
      int f0, i0, k;
      bit ok;
      f0 = n_fwd;
      i0 = n_ill;
      host.send(x, ok);
      for (k = 0; k < 60 && n_fwd == f0 && n_ill == i0; k++) @(negedge clk_sys);
      if (!ok || (ef + ei > 0 && k == 60)) begin
         error_cnt++;
         $display("BAD %0t no answer", $time);
         end_of_test();
      end
      repeat (4) @(negedge clk_sys);
      `CHK(n_fwd - f0, ef)
      `CHK(n_ill - i0, ei)
   endtask

   initial begin
      // Falling edge at time zero, after the initial 1, so the async reset branch really runs
      arst_n <= 1'b0;
      void'($urandom(32'hAF97F394));
      xs = 1'b0;
      repeat (5) @(posedge clk_sys);
      `CHK(blk, 12'h200)
      `CHK(st, LIDC_LS_DORMANT)
      arst_n <= 1'b1;
      repeat (4) @(posedge clk_link);
      issue(mk(LIDC_K_DEV_INIT), 0, 1);
      `CHK(ill_k, LIDC_K_DEV_INIT)
      c = mk(LIDC_K_DORMANT);
      c.deep_power_save_request = 1'b1;
      issue(c, 0, 1);
      `CHK(ill_k, LIDC_K_DORMANT)
      issue(mk(LIDC_K_PHY_READY), 0, 0);
      `CHK(st, LIDC_LS_CONFIG)
      c = mk(LIDC_K_INQUIRY);
      c.register_word_address = 8'h05;
      c.payload_length = 2'h2;
      issue(c, 0, 0);
      c.register_word_address = 8'h02;
      c.payload_length = 2'h3;
      issue(c, 1, 0);
      `CHK(last.payload, c.payload & {64'h0000_0000_0000_0200, 64'h0})
      c.register_word_address = 8'h00;
      c.payload_length = 2'h2;
      issue(c, 1, 0);
      `CHK(last.payload[63:0], c.payload[63:0] & 64'hFFFF_FFFF_00FF_C000)
      len = 12'($urandom_range(4095, 1));
      c = mk(LIDC_K_SET_COMMON);
      c.register_word_address = LIDC_LT_SET_LO;
      c.payload_length = 2'h1;
      c.payload[11:0] = len;
      issue(c, 1, 0);
      `CHK(blk, len)
      al = 12'($urandom_range(len, 1));
      @(posedge clk_sys);
      app <= 1'b1;
      app_len <= al;
      repeat (3) @(negedge clk_sys);
      `CHK(blk, al)
      @(posedge clk_sys);
      app <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         @(posedge clk_sys);
         own <= OW[i];
         done <= DN[i];
         c = mk(LIDC_K_DEV_INIT);
         c.group_number = 4'h0;
         c.group_power_budget = (i > 2) ? 4'($urandom_range(15, 1)) : GB[i];
         c.device_power_allowance = AL[i];
         c.completion_flag = 1'($urandom());
         eg = exp_gap(c, OW[i], xs, DN[i]);
         issue(c, 1, 0);
         `CHK(last.group_power_budget, eg)
         `CHK(last.completion_flag, c.completion_flag & DN[i])
         xs = xs | (eg != c.group_power_budget);
         `CHK(started, xs)
      end
      c = mk(LIDC_K_SET_COMMON);
      c.register_word_address = LIDC_GEN_SET_HI;
      c.payload_length = 2'h2;
      c.payload[31] = 1'b1;
      c.payload[39:38] = 2'h1;
      issue(c, 1, 0);
      `CHK(cfg_done, 1'b1)
      // No request bit: support was not confirmed
      issue(mk(LIDC_K_DORMANT), 1, 0);
      `CHK(st, LIDC_LS_DORMANT)
      `CHK(dps, 1'b0)
      `CHK(rng, 2'h1)
      `CHK(blk, len)
      issue(mk(LIDC_K_PHY_READY), 0, 0);
      `CHK(st, LIDC_LS_ACTIVE)
      c = mk(LIDC_K_ENUM);
      issue(c, 1, 0);
      `CHK(node, c.payload[3:0])
      `CHK(last.payload[3:0], 4'(c.payload[3:0] + 4'h1))
      issue(mk(LIDC_K_DEV_INIT), 0, 1);
      `CHK(ill_k, LIDC_K_DEV_INIT)
      end_of_test();
   end
endmodule
`default_nettype wire
